// ==== rtl/dbg_journal_pkg.sv ====
package dbg_journal_pkg;
    // -----------------------------------------------------------------
    // journal word layout
    // -----------------------------------------------------------------
    localparam int SRC_ID_MSB     = 31;
    localparam int SRC_ID_LSB     = 29;
    localparam int THREAD_ID_MSB  = 28;
    localparam int THREAD_ID_LSB  = 27;
    localparam int USER_DATA_MSB  = 26;
    localparam logic [2:0] HOST_SRC_ID    = 3'h7;
    localparam logic [1:0] HOST_THREAD_ID = 2'h0;
    // -----------------------------------------------------------------
    // engine constants
    // -----------------------------------------------------------------
    localparam logic [7:0] BREAK_IRQ_DATA = 8'h80;
    localparam logic [3:0] CTX_ALL_OFF    = 4'h0;
    localparam int         NUM_CTX        = 4;
    localparam int         CTX_W          = 2;
    localparam int         NUM_ENG        = 6;
    localparam int         ENG_W          = 3;
    localparam int         PTR_W          = 16;
    localparam int         PC_W           = 10;

    typedef enum logic [1:0] {
        EXEC_STOPPED,
        EXEC_RUNNING,
        EXEC_PAUSED
    } exec_state_t;
endpackage

// ==== rtl/engine_debug_journal.sv ====
// Function
// R1: host commands the engine into running or paused; state readable while paused.
// R2: with hop mode selected, each context-switch instruction pauses the engine.
// R3: host patches breakpoint branches only while the engine is paused or stopped.
// R4: writing zero context enables disables all contexts; arbiter schedules none.
// R5: quick write of 0x80 to thread interrupt flags raises breakpoint interrupt.
// R6: after a yield with all other contexts disabled, engine stays idle.
// R7: breakpoint code puts four instructions between enable write and yield.
// R8: on re-enable, arbiter first runs the thread named in next_context_select.
// R9: a woken thread resumes at the instruction after its yield.
// R10: a breakpoint affects only its own engine.
// R11: stopped or paused with loop bit set, engine loops on stored address.
// R12: alu output of the looping instruction is readable by the host.
// R13: host loads a pass-through alu instruction with a readable source operand.
// R14: journal keeps base, end and cursor pointers, each loaded separately; here the cursor is loaded only by the end write (set to base).
// R15: cursor write stores one word: source id, thread id, user data.
// R16: engine writes get ids inserted; host supplies ids 7 and 0 itself.
// R17: cursor increments after every journal word.
// R18: cursor equal to end wraps to base.
// R19: journaling enabled per engine.
// R20: base write loads base; end write loads end and resets cursor to base.
// R21: software writes base first, then end.
// R22: a per-engine hop enable selects auto-pause at context switches.
`timescale 1ns/1ps
`default_nettype none
module engine_debug_journal
    import dbg_journal_pkg::*;
#(
    parameter int ENG_ID = 0
) (
    input  wire logic               ref_clk_in,
    input  wire logic               rst_in,
    // host run control
    input  wire logic               host_run_in,
    input  wire logic               host_pause_in,
    input  wire logic               host_stop_in,
    input  wire logic               hop_enable_in,
    output logic [1:0]              exec_state_out,
    // context control
    input  wire logic               ctx_en_wr_in,
    input  wire logic [NUM_CTX-1:0] ctx_en_data_in,
    input  wire logic [CTX_W-1:0]   next_context_select_in,
    output logic [NUM_CTX-1:0]      ctx_en_out,
    output logic                    active_out,
    output logic [CTX_W-1:0]        active_ctx_out,
    output logic [PC_W-1:0]         pc_out,
    // instruction retire from engine pipeline
    input  wire logic               instr_valid_in,
    input  wire logic               instr_ctx_switch_in,
    input  wire logic               instr_yield_in,
    // thread interrupt flag quick write
    input  wire logic               flag_wr_in,
    input  wire logic [7:0]         flag_data_in,
    output logic                    break_irq_out,
    // stored instruction loop
    input  wire logic               loop_on_stored_instruction_in,
    input  wire logic [PC_W-1:0]    stored_word_address_in,
    input  wire logic [31:0]        alu_result_in,
    output logic [31:0]             alu_output_out,
    // journal
    input  wire logic               journal_enable_in,
    input  wire logic               base_wr_in,
    input  wire logic               end_wr_in,
    input  wire logic [PTR_W-1:0]   ptr_data_in,
    input  wire logic               cursor_wr_in,
    input  wire logic               cursor_from_host_in,
    input  wire logic [31:0]        cursor_data_in,
    output logic                    sram_wr_out,
    output logic [PTR_W-1:0]        sram_addr_out,
    output logic [31:0]             sram_data_out,
    output logic [PTR_W-1:0]        cursor_out
);
    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    typedef struct packed {
        exec_state_t          st;
        logic [NUM_CTX-1:0]   ctx_en;
        logic                 active;
        logic [CTX_W-1:0]     ctx;
        logic [PC_W-1:0]      pc;
        logic                 irq;
        logic [31:0]          alu;
        logic [PTR_W-1:0]     base;
        logic [PTR_W-1:0]     lim;
        logic [PTR_W-1:0]     cur;
        logic                 wr;
        logic [PTR_W-1:0]     addr;
        logic [31:0]          data;
    } state_t;

    state_t s_q;
    state_t s_d;

    logic looping;
    assign looping = loop_on_stored_instruction_in && (s_q.st != EXEC_RUNNING);

    always_comb begin
        s_d    = s_q;
        s_d.wr = 1'b0;
        // -------------------------------------------------------------
        // run control, local to this engine only
        // -------------------------------------------------------------
        if (host_stop_in) begin
            s_d.st = EXEC_STOPPED;
        end else if (host_pause_in) begin
            s_d.st = EXEC_PAUSED; // see R1
        end else if (host_run_in) begin
            s_d.st = EXEC_RUNNING; // see R1 see R10
        end else if (s_q.st == EXEC_RUNNING && hop_enable_in && instr_valid_in
                     && instr_ctx_switch_in) begin
            s_d.st = EXEC_PAUSED; // see R2 see R22
        end
        // -------------------------------------------------------------
        // context arbiter
        // -------------------------------------------------------------
        if (ctx_en_wr_in) begin
            s_d.ctx_en = ctx_en_data_in; // see R4
        end
        if (s_q.st == EXEC_RUNNING && s_q.active) begin
            if (instr_valid_in && instr_yield_in) begin
                s_d.active = 1'b0; // see R6
                s_d.pc     = s_q.pc + 1'b1; // see R9
            end else if (instr_valid_in) begin
                s_d.pc = s_q.pc + 1'b1;
            end
        end
        // a zero mask only blocks new starts: the running thread has to live
        // on long enough to reach its yield
        if (!s_q.active && s_q.st == EXEC_RUNNING
            && s_q.ctx_en[next_context_select_in]) begin
            s_d.active = 1'b1; // see R4 see R6 see R8
            s_d.ctx    = next_context_select_in;
        end
        // -------------------------------------------------------------
        // stored instruction loop and breakpoint interrupt
        // -------------------------------------------------------------
        if (looping) begin
            s_d.pc  = stored_word_address_in; // see R11
            s_d.alu = alu_result_in; // see R12
        end
        s_d.irq = flag_wr_in && (flag_data_in == BREAK_IRQ_DATA); // see R5
        // -------------------------------------------------------------
        // journal pointers
        // -------------------------------------------------------------
        if (base_wr_in) begin
            s_d.base = ptr_data_in; // see R14 see R20
        end
        if (end_wr_in) begin
            s_d.lim = ptr_data_in; // see R20
            s_d.cur = s_q.base; // see R20 see R21
        end else if (cursor_wr_in && (journal_enable_in || cursor_from_host_in)) begin
            s_d.wr   = 1'b1; // see R15 see R19
            s_d.addr = s_q.cur;
            if (cursor_from_host_in) begin
                s_d.data = cursor_data_in; // see R16
            end else begin
                s_d.data = {ENG_ID[ENG_W-1:0], s_q.ctx,
                            cursor_data_in[USER_DATA_MSB:0]}; // see R16
            end
            s_d.cur = (s_q.cur == s_q.lim) ? s_q.base : s_q.cur + 1'b1; // see R17 see R18
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign exec_state_out = s_q.st;
    assign ctx_en_out     = s_q.ctx_en;
    assign active_out     = s_q.active;
    assign active_ctx_out = s_q.ctx;
    assign pc_out         = s_q.pc;
    assign break_irq_out  = s_q.irq;
    assign alu_output_out = s_q.alu;
    assign sram_wr_out    = s_q.wr;
    assign sram_addr_out  = s_q.addr;
    assign sram_data_out  = s_q.data;
    assign cursor_out     = s_q.cur;

    // -----------------------------------------------------------------
    // assertions
    // -----------------------------------------------------------------
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    // -----------------------------------------------------------------
    // run control checks
    // -----------------------------------------------------------------
    a_run_cmd_taken: assert property (host_run_in && !host_pause_in && !host_stop_in
        |=> exec_state_out == EXEC_RUNNING) else $error("run not taken"); // see R1

    a_pause_cmd_taken: assert property (host_pause_in && !host_stop_in // see R1
        |=> exec_state_out == EXEC_PAUSED) else $error("pause not taken");

    a_stop_cmd_taken: assert property (host_stop_in // see R1
        |=> exec_state_out == EXEC_STOPPED) else $error("stop not taken");

    a_hop_auto_pause: assert property (exec_state_out == EXEC_RUNNING && hop_enable_in
        && instr_valid_in && instr_ctx_switch_in && !host_run_in && !host_stop_in
        |=> exec_state_out == EXEC_PAUSED) else $error("hop did not pause"); // see R2

    a_no_hop_runs: assert property (exec_state_out == EXEC_RUNNING // see R22
        && !hop_enable_in && !host_pause_in && !host_stop_in
        |=> exec_state_out == EXEC_RUNNING) else $error("paused without hop");

    // -----------------------------------------------------------------
    // context arbiter checks
    // -----------------------------------------------------------------
    a_ctx_en_load: assert property (ctx_en_wr_in // see R4
        |=> ctx_en_out == $past(ctx_en_data_in)) else $error("mask not loaded");

    a_ctx_all_off: assert property (ctx_en_out == CTX_ALL_OFF && !active_out // see R4
        |=> !active_out) else $error("context started with zero mask");

    a_yield_idle: assert property (active_out && exec_state_out == EXEC_RUNNING
        && instr_valid_in && instr_yield_in && !loop_on_stored_instruction_in
        |=> !active_out && pc_out == $past(pc_out) + 1'b1) else $error("yield bad"); // see R6

    a_wake_next_ctx: assert property (!active_out && exec_state_out == EXEC_RUNNING // see R8
        && ctx_en_out[next_context_select_in]
        |=> active_out && active_ctx_out == $past(next_context_select_in))
        else $error("wrong thread woken");

    // -----------------------------------------------------------------
    // breakpoint interrupt checks
    // -----------------------------------------------------------------
    a_break_irq: assert property (flag_wr_in && flag_data_in == BREAK_IRQ_DATA
        |=> break_irq_out) else $error("no break irq"); // see R5

    a_irq_only_break: assert property (!(flag_wr_in && flag_data_in == BREAK_IRQ_DATA)
        |=> !break_irq_out) else $error("stray break irq"); // see R5

    // -----------------------------------------------------------------
    // stored instruction loop checks
    // -----------------------------------------------------------------
    a_loop_stored: assert property (loop_on_stored_instruction_in
        && exec_state_out != EXEC_RUNNING
        |=> pc_out == $past(stored_word_address_in)
        && alu_output_out == $past(alu_result_in)) else $error("loop bad"); // see R11

    a_alu_held: assert property (!(loop_on_stored_instruction_in // see R12
        && exec_state_out != EXEC_RUNNING)
        |=> $stable(alu_output_out)) else $error("alu view moved");

    // -----------------------------------------------------------------
    // journal checks
    // -----------------------------------------------------------------
    a_base_load: assert property (base_wr_in // see R20
        |=> s_q.base == $past(ptr_data_in)) else $error("base not loaded");

    a_end_resets_cur: assert property (end_wr_in |=> cursor_out == $past(s_q.base))
        else $error("cursor not reset"); // see R20

    a_journal_off: assert property (cursor_wr_in && !journal_enable_in // see R19
        && !cursor_from_host_in |=> !sram_wr_out) else $error("write while off");

    a_cursor_step: assert property (cursor_wr_in && !end_wr_in && journal_enable_in // see R17
        && cursor_out != s_q.lim
        |=> cursor_out == $past(cursor_out) + 1'b1 && sram_addr_out == $past(cursor_out))
        else $error("cursor did not step");

    a_cursor_wrap: assert property (cursor_wr_in && !end_wr_in && journal_enable_in
        && cursor_out == s_q.lim |=> cursor_out == $past(s_q.base)
        && sram_wr_out) else $error("no wrap"); // see R18

    a_engine_word: assert property (cursor_wr_in && !end_wr_in && journal_enable_in // see R16
        && !cursor_from_host_in
        |=> sram_data_out[SRC_ID_MSB:SRC_ID_LSB] == ENG_ID[ENG_W-1:0]
        && sram_data_out[THREAD_ID_MSB:THREAD_ID_LSB] == $past(active_ctx_out))
        else $error("engine ids wrong");

    a_host_word: assert property (cursor_wr_in && !end_wr_in && cursor_from_host_in
        |=> sram_data_out == $past(cursor_data_in)) else $error("host word"); // see R16

    // -----------------------------------------------------------------
    // coverage
    // -----------------------------------------------------------------
    c_hop: cover property (hop_enable_in && instr_ctx_switch_in ##1
        exec_state_out == EXEC_PAUSED);
    c_wrap: cover property (sram_wr_out && cursor_out == s_q.base);
    c_loop: cover property (exec_state_out == EXEC_PAUSED && loop_on_stored_instruction_in);
    c_irq: cover property (break_irq_out);
    c_wake: cover property (!active_out ##1 active_out);
endmodule
`default_nettype wire

// ==== dv/journal_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module journal_host_model
    import dbg_journal_pkg::*;
(
    input  wire logic             ref_clk_in,
    output logic                  base_wr_out,
    output logic                  end_wr_out,
    output logic [PTR_W-1:0]      ptr_data_out,
    output logic                  cursor_wr_out,
    output logic                  cursor_from_host_out,
    output logic [31:0]           cursor_data_out
);
    initial begin
        {base_wr_out, end_wr_out, cursor_wr_out, cursor_from_host_out} = 4'h0;
        {ptr_data_out, cursor_data_out} = '0;
    end
    // base goes first so the end write restarts the cursor at the new base
    task automatic init_ptrs(input logic [PTR_W-1:0] b, input logic [PTR_W-1:0] e);
        @(negedge ref_clk_in);
        base_wr_out = 1'h1;
        ptr_data_out = b;
        @(negedge ref_clk_in);
        base_wr_out = 1'h0;
        end_wr_out = 1'h1;
        ptr_data_out = e;
        @(negedge ref_clk_in);
        end_wr_out = 1'h0;
        ptr_data_out = ~e;
    endtask
    // engine words carry junk ids on purpose: the unit must overwrite them
    task automatic log_word(input logic host, input logic [26:0] d);
        @(negedge ref_clk_in);
        cursor_wr_out = 1'h1;
        cursor_from_host_out = host;
        cursor_data_out = host ? {HOST_SRC_ID, HOST_THREAD_ID, d} : {5'h1b, d};
        @(negedge ref_clk_in);
    endtask
    task automatic log_end();
        cursor_wr_out = 1'h0;
        cursor_data_out = ~cursor_data_out;
    endtask
endmodule
`default_nettype wire

// ==== dv/engine_debug_journal_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module engine_debug_journal_tb_top
    import dbg_journal_pkg::*;
;
    localparam int ENG = 5;
    logic ref_clk_in = 1'h0;
    logic rst_in = 1'h1;
    logic host_run_in, host_pause_in, host_stop_in, hop_enable_in, ctx_en_wr_in;
    logic instr_valid_in, instr_ctx_switch_in, instr_yield_in, flag_wr_in;
    logic loop_on_stored_instruction_in, journal_enable_in, base_wr_in, end_wr_in;
    logic cursor_wr_in, cursor_from_host_in, break_irq_out, active_out, sram_wr_out;
    logic [NUM_CTX-1:0] ctx_en_data_in, ctx_en_out;
    logic [CTX_W-1:0]   next_context_select_in, active_ctx_out;
    logic [1:0]         exec_state_out;
    logic [7:0]         flag_data_in;
    logic [PC_W-1:0]    stored_word_address_in, pc_out, pc0;
    logic [31:0]        alu_result_in, alu_output_out, cursor_data_in, sram_data_out, exp_w;
    logic [PTR_W-1:0]   ptr_data_in, sram_addr_out, cursor_out;
    int                 err_count = 0;
    int                 samples_checked = 0;
    typedef struct packed {
        logic             en;
        logic             host;
        logic [26:0]      d;
        logic             wr;
        logic [PTR_W-1:0] a;
    } row_t;
    row_t rows [5] = '{'{1'h1, 1'h0, 27'h123, 1'h1, 16'h10}, '{1'h0, 1'h1, 27'h456, 1'h1, 16'h11},
                       '{1'h0, 1'h0, 27'h789, 1'h0, 16'h0}, '{1'h1, 1'h0, 27'h7ffffff, 1'h1, 16'h12},
                       '{1'h1, 1'h1, 27'h0, 1'h1, 16'h10}};
    always #5 ref_clk_in = ~ref_clk_in;
    engine_debug_journal #(.ENG_ID(ENG)) dut (
        .ref_clk_in                    (ref_clk_in),
        .rst_in                        (rst_in),
        .host_run_in                   (host_run_in),
        .host_pause_in                 (host_pause_in),
        .host_stop_in                  (host_stop_in),
        .hop_enable_in                 (hop_enable_in),
        .exec_state_out                (exec_state_out),
        .ctx_en_wr_in                  (ctx_en_wr_in),
        .ctx_en_data_in                (ctx_en_data_in),
        .next_context_select_in        (next_context_select_in),
        .ctx_en_out                    (ctx_en_out),
        .active_out                    (active_out),
        .active_ctx_out                (active_ctx_out),
        .pc_out                        (pc_out),
        .instr_valid_in                (instr_valid_in),
        .instr_ctx_switch_in           (instr_ctx_switch_in),
        .instr_yield_in                (instr_yield_in),
        .flag_wr_in                    (flag_wr_in),
        .flag_data_in                  (flag_data_in),
        .break_irq_out                 (break_irq_out),
        .loop_on_stored_instruction_in (loop_on_stored_instruction_in),
        .stored_word_address_in        (stored_word_address_in),
        .alu_result_in                 (alu_result_in),
        .alu_output_out                (alu_output_out),
        .journal_enable_in             (journal_enable_in),
        .base_wr_in                    (base_wr_in),
        .end_wr_in                     (end_wr_in),
        .ptr_data_in                   (ptr_data_in),
        .cursor_wr_in                  (cursor_wr_in),
        .cursor_from_host_in           (cursor_from_host_in),
        .cursor_data_in                (cursor_data_in),
        .sram_wr_out                   (sram_wr_out),
        .sram_addr_out                 (sram_addr_out),
        .sram_data_out                 (sram_data_out),
        .cursor_out                    (cursor_out)
    );
    journal_host_model host (.ref_clk_in(ref_clk_in), .base_wr_out(base_wr_in),
        .end_wr_out(end_wr_in), .ptr_data_out(ptr_data_in), .cursor_wr_out(cursor_wr_in),
        .cursor_from_host_out(cursor_from_host_in), .cursor_data_out(cursor_data_in));
    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk_in);
    endtask
    task automatic pulse(ref logic s);
        tick(1);
        s = 1'h1;
        tick(1);
        s = 1'h0;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // -----------------------------------------------------------------
    // tests
    // -----------------------------------------------------------------
    initial begin
        {host_run_in, host_pause_in, host_stop_in, hop_enable_in, ctx_en_wr_in} = 5'h0;
        {instr_valid_in, instr_ctx_switch_in, instr_yield_in, flag_wr_in} = 4'h0;
        {loop_on_stored_instruction_in, journal_enable_in, ctx_en_data_in} = '0;
        {next_context_select_in, flag_data_in, stored_word_address_in, alu_result_in} = '0;
        tick(10);
        rst_in = 1'h0;
        host.init_ptrs(16'h10, 16'h12);
        check("cursor init", cursor_out, 32'h10);
        foreach (rows[i]) begin
            journal_enable_in = rows[i].en;
            host.log_word(rows[i].host, rows[i].d);
            exp_w = rows[i].host ? {HOST_SRC_ID, HOST_THREAD_ID, rows[i].d} : {3'(ENG), 2'h0, rows[i].d};
            check("journal wr", sram_wr_out, rows[i].wr);
            if (rows[i].wr) begin
                check("journal addr", sram_addr_out, rows[i].a);
                check("journal word", sram_data_out, exp_w);
                check("cursor", cursor_out, rows[i].a == 16'h12 ? 32'h10 : rows[i].a + 1);
            end
            host.log_end();
        end
        $display("journal table done");
        pulse(host_run_in);
        check("run", exec_state_out, 32'h1);
        pulse(host_pause_in);
        check("pause", exec_state_out, 32'h2);
        pulse(host_run_in);
        hop_enable_in = 1'h1;
        instr_ctx_switch_in = 1'h1;
        pulse(instr_valid_in);
        instr_ctx_switch_in = 1'h0;
        hop_enable_in = 1'h0;
        check("hop pause", exec_state_out, 32'h2);
        pulse(host_stop_in);
        check("stop", exec_state_out, 32'h0);
        flag_data_in = BREAK_IRQ_DATA;
        pulse(flag_wr_in);
        check("irq", break_irq_out, 32'h1);
        tick(1);
        check("irq pulse", break_irq_out, 32'h0);
        flag_data_in = 8'h40;
        pulse(flag_wr_in);
        check("irq other", break_irq_out, 32'h0);
        $display("run control and irq done");
        ctx_en_data_in = 4'hf;
        next_context_select_in = 2'h2;
        pulse(ctx_en_wr_in);
        pulse(host_run_in);
        tick(2);
        check("active", active_out, 32'h1);
        check("active ctx", active_ctx_out, 32'h2);
        ctx_en_data_in = CTX_ALL_OFF;
        pulse(ctx_en_wr_in);
        check("ctx off", ctx_en_out, 32'h0);
        pc0 = pc_out;
        repeat (4) pulse(instr_valid_in);
        check("gap pc", pc_out, 32'(pc0) + 32'h4);
        check("still active", active_out, 32'h1);
        instr_yield_in = 1'h1;
        pulse(instr_valid_in);
        instr_yield_in = 1'h0;
        check("yield pc", pc_out, 32'(pc0) + 32'h5);
        tick(4);
        check("idle", active_out, 32'h0);
        ctx_en_data_in = 4'h2;
        next_context_select_in = 2'h1;
        pulse(ctx_en_wr_in);
        tick(2);
        check("wake", active_out, 32'h1);
        check("wake ctx", active_ctx_out, 32'h1);
        check("wake pc", pc_out, 32'(pc0) + 32'h5);
        journal_enable_in = 1'h1;
        host.log_word(1'h0, 27'h2a);
        check("thread id", sram_data_out, {3'(ENG), 2'h1, 27'h2a});
        host.log_end();
        $display("context test done");
        pulse(host_pause_in);
        loop_on_stored_instruction_in = 1'h1;
        stored_word_address_in = 10'h155;
        alu_result_in = 32'h5a5a0f0f;
        tick(2);
        check("alu view", alu_output_out, 32'h5a5a0f0f);
        check("loop pc", pc_out, 32'h155);
        alu_result_in = 32'h0;
        tick(1);
        check("alu follow", alu_output_out, 32'h0);
        rst_in = 1'h1;
        tick(1);
        check("rst state", exec_state_out, 32'h0);
        check("rst ctx", ctx_en_out, 32'h0);
        check("rst cursor", cursor_out, 32'h0);
        check("rst active", active_out, 32'h0);
        rst_in = 1'h0;
        $display("loop and reset done");
        summarize();
    end
    initial begin
        #100000;
        err_count++;
        summarize();
    end
endmodule
`default_nettype wire
